// [tdo_pkg.sv]
// shared constants and types for the touch detect output logic
package tdo_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int BURST_MS = 75;
    localparam int CONFIRM_MS = 20;
    localparam int TONE_MS = 95;
    localparam int PULSE_MS = 75;
    localparam int HEALTH_US = 350;
    localparam int TONE_HZ = 4000;
    localparam int TIMEOUT_SHORT_S = 10;
    localparam int TIMEOUT_LONG_S = 60;
    // one millisecond tick derived from the system clock
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int HEALTH_CYCLES = (HEALTH_US * (CLK_HZ / 1000000));
    localparam int TONE_HALF_CYCLES = CLK_HZ / (2 * TONE_HZ);
    localparam int INTEG_LIMIT = 4;
    localparam int CAL_BURSTS = 4;
    // edges after reset before the strap synchronisers hold real pin levels
    localparam int STRAP_FILL = 3;
    localparam logic [15:0] REF_RESET = 16'h0000;
    // threshold differential as a shift of the burst signal: high, medium, low gain
    localparam int SHIFT_HIGH = 5;
    localparam int SHIFT_MED = 4;
    localparam int SHIFT_LOW = 3;
    localparam int RISE_DIV = 16;
    localparam logic [15:0] FALL_STEP = 16'h0004;
    localparam logic [15:0] RISE_STEP = 16'h0001;

    typedef enum logic [1:0] {
        TDO_LEVEL = 2'b00,
        TDO_TOGGLE = 2'b01,
        TDO_PULSE = 2'b11
    } tdo_mode_e;

    typedef enum logic [1:0] {
        TDO_GAIN_HIGH = 2'b00,
        TDO_GAIN_MED = 2'b01,
        TDO_GAIN_LOW = 2'b11
    } tdo_gain_e;

    typedef enum logic [1:0] {
        TDO_ST_CAL = 2'b00,
        TDO_ST_IDLE = 2'b01,
        TDO_ST_HEALTH = 2'b11,
        TDO_ST_ACQ = 2'b10
    } tdo_state_e;
endpackage

// [tdo_timebase_if.sv]
// timebase ticks shared between the top and the divider
interface tdo_timebase_if;
    logic ms_tick;
    logic tone_tick;
    modport src (output ms_tick, output tone_tick);
    modport dst (input ms_tick, input tone_tick);
endinterface

// [tdo_timebase.sv]
// clock dividers giving the millisecond and tone half-period enables
module tdo_timebase #(
    parameter int MS_CYCLES = tdo_pkg::MS_CYCLES,
    parameter int TONE_HALF_CYCLES = tdo_pkg::TONE_HALF_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // ticks
    tdo_timebase_if.src tb
);
    logic [15:0] ms_cnt;
    logic [15:0] tone_cnt;

    // single slow oscillator stand-in: all timing but the health window derives from these [RULE24]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt <= 16'h0000;
        end else if (ms_cnt == 16'(MS_CYCLES - 1)) begin
            ms_cnt <= 16'h0000;
        end else begin
            ms_cnt <= ms_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tone_cnt <= 16'h0000;
        end else if (tone_cnt == 16'(TONE_HALF_CYCLES - 1)) begin
            tone_cnt <= 16'h0000;
        end else begin
            tone_cnt <= tone_cnt + 16'h0001;
        end
    end

    assign tb.ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));
    assign tb.tone_tick = (tone_cnt == 16'(TONE_HALF_CYCLES - 1));
endmodule

// [tdo_touch_detect.sv]
// touch detect back end: reference tracking, integrator, timeout, output and tone
// Operation
// [RULE1] reference slews toward signal only when no detection; frozen while detecting
// [RULE2] reference follows falling signal much faster than rising signal
// [RULE3] threshold is reference plus a fraction of signal level, recomputed continuously
// [RULE4] detection ends when signal drops below threshold minus half the differential
// [RULE5] detection longer than the selected timeout forces full recalibration
// [RULE6] after timeout recalibration present signal becomes the new baseline
// [RULE7] integrator counts detecting bursts to four, clears at once on a miss
// [RULE8] bursts every 75 ms, confirmation bursts every 20 ms
// [RULE9] no recalibration input; forced recalibration only at power-up; the code also recalibrates after a hold timeout
// [RULE10] straps sampled once after power-up and held until next power-up
// [RULE11] two mode straps select level 10 s, level 60 s, toggle or pulse
// [RULE12] output idles high and is driven low while active
// [RULE13] level mode holds output low during detection, released on timeout
// [RULE14] toggle mode inverts output per detection; timeout leaves state
// [RULE15] pulse mode gives one 75 ms low pulse per new detection
// [RULE16] a 95 ms tone starts immediately after a detection is made
// [RULE17] tone drives the two sense terminals in opposite phase
// [RULE18] tone is disabled in pulse mode
// [RULE19] output floats 350 us before every burst as a health indication
// [RULE20] monitor uses a pull-down and counts low pulses while output inactive
// [RULE21] gain strap open, on terminal a, or on terminal b picks high, medium, low
// [RULE22] tone is a square wave near 4 kHz
// [RULE23] calibration clears integrator and timer and loads reference from fresh bursts
// [RULE24] all intervals derive from one internal timebase, approximate accuracy
module tdo_touch_detect #(
    parameter int SIG_W = 16,
    parameter int MS_CYCLES = tdo_pkg::MS_CYCLES,
    parameter int HEALTH_CYCLES = tdo_pkg::HEALTH_CYCLES,
    parameter int TONE_HALF_CYCLES = tdo_pkg::TONE_HALF_CYCLES,
    parameter int TIMEOUT_SHORT_MS = tdo_pkg::TIMEOUT_SHORT_S * 1000,
    parameter int TIMEOUT_LONG_MS = tdo_pkg::TIMEOUT_LONG_S * 1000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // converter interface
    output logic burst_req,
    input wire logic burst_done,
    input wire logic [SIG_W-1:0] burst_signal,
    // straps from pins
    input wire logic mode_strap_a,
    input wire logic mode_strap_b,
    input wire logic gain_strap_open,
    input wire logic gain_strap_on_a,
    // output pin
    output logic out_n_o,
    output logic out_n_oe,
    // sounder bridge on the sense terminals
    output logic sense_terminal_a_o,
    output logic sense_terminal_b_o,
    output logic sense_terminal_oe,
    // status
    output logic detect
);
    tdo_timebase_if tb();
    tdo_timebase #(.MS_CYCLES(MS_CYCLES), .TONE_HALF_CYCLES(TONE_HALF_CYCLES)) u_tb (
        .clk(clk), .rst_n(rst_n), .tb(tb));

    logic [2:0] sa_sync, sb_sync, go_sync, ga_sync;
    logic straps_taken;
    logic [1:0] strap_fill;
    tdo_pkg::tdo_mode_e mode;
    tdo_pkg::tdo_gain_e gain;
    logic long_timeout;
    tdo_pkg::tdo_state_e state;
    logic [15:0] phase_cnt;
    logic [SIG_W-1:0] ref_lvl;
    logic [SIG_W-1:0] delta;
    logic [SIG_W:0] thresh;
    logic [SIG_W:0] release_lvl;
    logic [2:0] integ;
    logic [2:0] cal_cnt;
    logic [3:0] rise_div;
    logic [16:0] hold_ms;
    logic [6:0] tone_ms;
    logic [6:0] pulse_ms;
    logic toggle_state;
    logic tone_phase;
    logic hit;
    logic timeout;
    logic new_detect;

    // three-stage pin synchronisers, straps only counted once stable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sa_sync <= 3'h0;
            sb_sync <= 3'h0;
            go_sync <= 3'h0;
            ga_sync <= 3'h0;
            strap_fill <= 2'h0;
        end else begin
            // reset zeros would look stable, so wait until the pipeline holds pin levels
            if (strap_fill != 2'(tdo_pkg::STRAP_FILL)) begin
                strap_fill <= strap_fill + 2'h1;
            end
            sa_sync <= {sa_sync[1:0], mode_strap_a};
            sb_sync <= {sb_sync[1:0], mode_strap_b};
            go_sync <= {go_sync[1:0], gain_strap_open};
            ga_sync <= {ga_sync[1:0], gain_strap_on_a};
        end
    end

    // straps latched once after power-up; no later input can recalibrate [RULE10] [RULE9]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            straps_taken <= 1'b0;
            mode <= tdo_pkg::TDO_LEVEL;
            gain <= tdo_pkg::TDO_GAIN_HIGH;
            long_timeout <= 1'b0;
        end else if (!straps_taken && strap_fill == 2'(tdo_pkg::STRAP_FILL)
                     && sa_sync[2] == sa_sync[1] && sb_sync[2] == sb_sync[1]
                     && go_sync[2] == go_sync[1] && ga_sync[2] == ga_sync[1]) begin
            straps_taken <= 1'b1;
            // strap decode [RULE11]
            long_timeout <= sa_sync[2] && !sb_sync[2];
            if (sa_sync[2]) begin
                mode <= tdo_pkg::TDO_LEVEL;
            end else if (sb_sync[2]) begin
                mode <= tdo_pkg::TDO_PULSE;
            end else begin
                mode <= tdo_pkg::TDO_TOGGLE;
            end
            // gain strap [RULE21]
            if (go_sync[2]) begin
                gain <= tdo_pkg::TDO_GAIN_HIGH;
            end else if (ga_sync[2]) begin
                gain <= tdo_pkg::TDO_GAIN_MED;
            end else begin
                gain <= tdo_pkg::TDO_GAIN_LOW;
            end
        end
    end

    // ratiometric differential and hysteresis release [RULE3] [RULE4]
    always_comb begin
        case (gain)
            tdo_pkg::TDO_GAIN_MED: delta = burst_signal >> tdo_pkg::SHIFT_MED;
            tdo_pkg::TDO_GAIN_LOW: delta = burst_signal >> tdo_pkg::SHIFT_LOW;
            default: delta = burst_signal >> tdo_pkg::SHIFT_HIGH;
        endcase
        thresh = {1'b0, ref_lvl} + {1'b0, delta};
        release_lvl = thresh - {2'b00, delta[SIG_W-1:1]};
    end

    assign hit = detect ? ({1'b0, burst_signal} >= release_lvl)
                        : ({1'b0, burst_signal} > thresh);
    assign timeout = detect && tb.ms_tick &&
        (hold_ms == 17'(long_timeout ? TIMEOUT_LONG_MS - 1 : TIMEOUT_SHORT_MS - 1));
    assign new_detect = burst_done && state == tdo_pkg::TDO_ST_ACQ && !detect && hit
        && integ == 3'(tdo_pkg::INTEG_LIMIT - 1);

    // burst sequencer: calibration, idle spacing, health window, acquisition
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= tdo_pkg::TDO_ST_CAL;
            phase_cnt <= 16'h0000;
        end else begin
            case (state)
                tdo_pkg::TDO_ST_CAL, tdo_pkg::TDO_ST_IDLE: begin
                    if (timeout) begin
                        state <= tdo_pkg::TDO_ST_CAL;
                        phase_cnt <= 16'h0000;
                    end else if (!straps_taken) begin
                        phase_cnt <= 16'h0000;
                    end else if (tb.ms_tick) begin
                        // short spacing while confirming [RULE8]
                        if (phase_cnt >= 16'(((integ != 3'h0 || state == tdo_pkg::TDO_ST_CAL)
                                ? tdo_pkg::CONFIRM_MS : tdo_pkg::BURST_MS) - 1)) begin
                            state <= tdo_pkg::TDO_ST_HEALTH;
                            phase_cnt <= 16'h0000;
                        end else begin
                            phase_cnt <= phase_cnt + 16'h0001;
                        end
                    end
                end
                tdo_pkg::TDO_ST_HEALTH: begin
                    // health float before each burst [RULE19]
                    if (phase_cnt == 16'(HEALTH_CYCLES - 1)) begin
                        state <= tdo_pkg::TDO_ST_ACQ;
                        phase_cnt <= 16'h0000;
                    end else begin
                        phase_cnt <= phase_cnt + 16'h0001;
                    end
                end
                default: begin
                    if (burst_done) begin
                        // last calibration burst already returns to normal spacing
                        state <= (cal_cnt < 3'(tdo_pkg::CAL_BURSTS - 1))
                            ? tdo_pkg::TDO_ST_CAL : tdo_pkg::TDO_ST_IDLE;
                        phase_cnt <= 16'h0000;
                    end
                end
            endcase
        end
    end

    assign burst_req = (state == tdo_pkg::TDO_ST_ACQ);

    // calibration burst counter; calibrating until it reaches CAL_BURSTS [RULE23]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_cnt <= 3'h0;
        end else if (timeout) begin
            cal_cnt <= 3'h0;
        end else if (burst_done && state == tdo_pkg::TDO_ST_ACQ
                     && cal_cnt != 3'(tdo_pkg::CAL_BURSTS)) begin
            cal_cnt <= cal_cnt + 3'h1;
        end
    end

    // reference: loaded during calibration, asymmetric slew otherwise [RULE1] [RULE2] [RULE6]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_lvl <= SIG_W'(tdo_pkg::REF_RESET);
            rise_div <= 4'h0;
        end else if (burst_done && state == tdo_pkg::TDO_ST_ACQ) begin
            if (cal_cnt != 3'(tdo_pkg::CAL_BURSTS)) begin
                ref_lvl <= burst_signal;
            end else if (!detect && integ == 3'h0 && !hit) begin
                if (burst_signal < ref_lvl) begin
                    ref_lvl <= (ref_lvl - burst_signal > SIG_W'(tdo_pkg::FALL_STEP))
                        ? ref_lvl - SIG_W'(tdo_pkg::FALL_STEP) : burst_signal;
                end else if (burst_signal > ref_lvl) begin
                    rise_div <= rise_div + 4'h1;
                    if (rise_div == 4'(tdo_pkg::RISE_DIV - 1)) begin
                        ref_lvl <= ref_lvl + SIG_W'(tdo_pkg::RISE_STEP);
                    end
                end
            end
        end
    end

    // integrator and detect flag [RULE7] [RULE4] [RULE23]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            integ <= 3'h0;
            detect <= 1'b0;
        end else if (timeout) begin
            integ <= 3'h0;
            detect <= 1'b0;
        end else if (burst_done && state == tdo_pkg::TDO_ST_ACQ
                     && cal_cnt == 3'(tdo_pkg::CAL_BURSTS)) begin
            if (detect) begin
                detect <= hit;
            end else if (!hit) begin
                integ <= 3'h0;
            end else if (new_detect) begin
                integ <= 3'h0;
                detect <= 1'b1;
            end else begin
                integ <= integ + 3'h1;
            end
        end
    end

    // hold timer measures each continuous detection [RULE5]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_ms <= 17'h00000;
        end else if (!detect || timeout) begin
            hold_ms <= 17'h00000;
        end else if (tb.ms_tick) begin
            hold_ms <= hold_ms + 17'h00001;
        end
    end

    // toggle flip-flop, untouched by timeout [RULE14]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_state <= 1'b0;
        end else if (new_detect && mode == tdo_pkg::TDO_TOGGLE && cal_cnt == 3'(tdo_pkg::CAL_BURSTS)) begin
            toggle_state <= !toggle_state;
        end
    end

    // pulse and tone timers [RULE15] [RULE16] [RULE18]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_ms <= 7'h00;
            tone_ms <= 7'h00;
        end else if (new_detect && cal_cnt == 3'(tdo_pkg::CAL_BURSTS)) begin
            pulse_ms <= (mode == tdo_pkg::TDO_PULSE) ? 7'(tdo_pkg::PULSE_MS) : 7'h00;
            tone_ms <= (mode == tdo_pkg::TDO_PULSE) ? 7'h00 : 7'(tdo_pkg::TONE_MS);
        end else if (tb.ms_tick) begin
            if (pulse_ms != 7'h00) begin
                pulse_ms <= pulse_ms - 7'h01;
            end
            if (tone_ms != 7'h00) begin
                tone_ms <= tone_ms - 7'h01;
            end
        end
    end

    // square tone near 4 kHz [RULE22]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tone_phase <= 1'b0;
        end else if (tone_ms == 7'h00) begin
            tone_phase <= 1'b0;
        end else if (tb.tone_tick) begin
            tone_phase <= !tone_phase;
        end
    end

    // bridge drive, opposite phases; not during acquisition [RULE17]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_terminal_a_o <= 1'b0;
            sense_terminal_b_o <= 1'b0;
            sense_terminal_oe <= 1'b0;
        end else begin
            sense_terminal_a_o <= tone_phase;
            sense_terminal_b_o <= !tone_phase;
            sense_terminal_oe <= (tone_ms != 7'h00) && !burst_req;
        end
    end

    // active-low output with health float [RULE12] [RULE13] [RULE19]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_n_o <= 1'b1;
            out_n_oe <= 1'b1;
        end else begin
            case (mode)
                tdo_pkg::TDO_TOGGLE: out_n_o <= !toggle_state;
                tdo_pkg::TDO_PULSE: out_n_o <= (pulse_ms == 7'h00);
                default: out_n_o <= !detect;
            endcase
            out_n_oe <= (state != tdo_pkg::TDO_ST_HEALTH);
        end
    end

    chk_health_float: assert property (@(posedge clk) disable iff (!rst_n)
        (state == tdo_pkg::TDO_ST_HEALTH) |=> !out_n_oe) // [RULE19]
        else $error("output driven during health window");
    chk_level_follows: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == tdo_pkg::TDO_LEVEL && straps_taken) |=> out_n_o == !$past(detect)) // [RULE13]
        else $error("level output does not follow detection");
    chk_ref_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        (detect && cal_cnt == 3'(tdo_pkg::CAL_BURSTS) && !timeout) |=> $stable(ref_lvl)) // [RULE1]
        else $error("reference moved during detection");
    chk_integ_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (burst_done && state == tdo_pkg::TDO_ST_ACQ && !detect && !hit && !timeout)
        |=> integ == 3'h0) // [RULE7]
        else $error("integrator not cleared on miss");
    chk_integ_bound: assert property (@(posedge clk) disable iff (!rst_n)
        integ < 3'(tdo_pkg::INTEG_LIMIT)) // [RULE7]
        else $error("integrator past limit");
    chk_no_pulse_tone: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == tdo_pkg::TDO_PULSE) |-> tone_ms == 7'h00) // [RULE18]
        else $error("tone in pulse mode");
    chk_bridge_phase: assert property (@(posedge clk) disable iff (!rst_n)
        sense_terminal_oe |-> sense_terminal_a_o != sense_terminal_b_o) // [RULE17]
        else $error("bridge terminals in phase");
    chk_timeout_clears: assert property (@(posedge clk) disable iff (!rst_n)
        timeout |=> !detect && hold_ms == 17'h00000 && cal_cnt == 3'h0) // [RULE5]
        else $error("timeout did not recalibrate");
    chk_toggle_keep: assert property (@(posedge clk) disable iff (!rst_n)
        timeout |=> $stable(toggle_state)) // [RULE14]
        else $error("timeout changed toggle state");
    chk_straps_held: assert property (@(posedge clk) disable iff (!rst_n)
        $past(straps_taken) |-> $stable(mode) && $stable(gain)) // [RULE10]
        else $error("straps changed after capture");

    cov_detect: cover property (@(posedge clk) disable iff (!rst_n) $rose(detect));
    cov_timeout: cover property (@(posedge clk) disable iff (!rst_n) timeout);
    cov_tone: cover property (@(posedge clk) disable iff (!rst_n) $rose(sense_terminal_oe));
    cov_health: cover property (@(posedge clk) disable iff (!rst_n) $fell(out_n_oe));
endmodule

// [tdo_load_model.sv]
// external load on the output pin: pull-down plus a counter of low-going pulses
module tdo_load_model (
    // pin drive from the device
    input wire logic out_n_o,
    input wire logic out_n_oe,
    // resolved pin and pulse count
    output logic pin,
    output int unsigned hb_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pin falls to the pull-down, so health pulses show only while idle high
    assign pin = out_n_oe ? out_n_o : 1'b0;
    initial begin
        hb_count = 0;
        forever begin
            @(negedge pin);
            hb_count++;
        end
    end
endmodule

// [tdo_touch_detect_tb.sv]
// self-checking bench for the touch detect output logic
module tdo_touch_detect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // scaled timebase keeps the tone ratio but makes a millisecond 24 cycles
    localparam int MS = 24;
    localparam int HB = 8;
    localparam int TH = 3;
    // shortened hold timeout keeps the run bearable
    localparam int TO = 200;
    logic clk, rst_n, burst_req, burst_done, out_n_o, out_n_oe, detect, pin;
    logic sta, stb, g_open, g_a, s_a, s_b, s_oe, dprev, tone_seen, aprev;
    logic [15:0] burst_signal, sig, base;
    int unsigned hb;
    int fails = 0, checked = 0, nb = 0, cyc = 0, last = 0, gap = 0, dstamp = 0;
    int ton = 0, tcnt = 0, thalf = 1000000, lowc = 0, hlen = 0, plen = 0;

    tdo_touch_detect #(.MS_CYCLES(MS), .HEALTH_CYCLES(HB), .TONE_HALF_CYCLES(TH),
        .TIMEOUT_SHORT_MS(TO), .TIMEOUT_LONG_MS(2 * TO)) dut_u (
        .clk(clk), .rst_n(rst_n), .burst_req(burst_req), .burst_done(burst_done),
        .burst_signal(burst_signal), .mode_strap_a(sta), .mode_strap_b(stb),
        .gain_strap_open(g_open), .gain_strap_on_a(g_a), .out_n_o(out_n_o),
        .out_n_oe(out_n_oe), .sense_terminal_a_o(s_a), .sense_terminal_b_o(s_b),
        .sense_terminal_oe(s_oe), .detect(detect));
    tdo_load_model load_u (.out_n_o(out_n_o), .out_n_oe(out_n_oe), .pin(pin), .hb_count(hb));

    function automatic logic [15:0] above(input logic [15:0] b, input int sh, input int q);
        // q quarters of the differential above the base level
        return b + 16'(((b >> sh) * q) / 4);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic bursts(input int n, input logic [15:0] v);
        int t0;
        sig = v;
        t0 = nb;
        for (int i = 0; i < n * 80 * MS && nb < t0 + n; i++) @(posedge clk);
        #1;
    endtask

    task automatic power_up(input logic a, input logic b, input logic op, input logic oa);
        rst_n = 0;
        {sta, stb, g_open, g_a} = {a, b, op, oa};
        base = 16'h0800 + 16'($urandom_range(4095, 0));
        repeat (4) @(posedge clk);
        #1;
        chk({out_n_o, out_n_oe, detect, burst_req}, 4'b1100);
        rst_n = 1;
        bursts(4, base);
    endtask

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    // converter: answers each burst request after a random short delay
    initial begin
        burst_done = 0;
        burst_signal = 0;
        forever begin
            @(posedge clk);
            #1;
            if (burst_req === 1'b1) begin
                repeat ($urandom_range(3, 0)) begin
                    @(posedge clk);
                    #1;
                end
                burst_done = 1;
                burst_signal = sig;
                @(posedge clk);
                #1;
                burst_done = 0;
                burst_signal = ~sig;
                nb++;
                gap = cyc - last;
                last = cyc;
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (detect === 1'b1 && dprev !== 1'b1) begin
            dstamp = cyc;
            ton = 0;
        end
        dprev = detect;
        if (out_n_oe === 1'b0) begin
            lowc++;
        end else if (lowc > 0) begin
            hlen = lowc;
            lowc = 0;
        end
        if (out_n_o === 1'b0) plen++;
        if (s_oe === 1'b1) begin
            tone_seen = 1;
            ton++;
            chk(s_a ^ s_b, 1);
        end
        tcnt++;
        // only edges while the bridge drives count; the forced stop is no half period
        if (s_a !== aprev && s_oe === 1'b1) begin
            if (tcnt < thalf) thalf = tcnt;
            tcnt = 0;
        end
        aprev = s_a;
    end

    initial begin
        repeat (3800 * MS) @(posedge clk);
        fails++;
        end_sim;
    end

    initial begin
        rst_n = 0;
        {sta, stb, g_open, g_a} = 4'hf;
        sig = 16'h0000;
        void'($urandom(32'h5d52));
        power_up(1, 1, 1, 0);
        chk(detect, 0);
        chk(hb, 4);
        sta = 0;
        bursts(3, above(base, 5, 8));
        bursts(1, base);
        chk(gap >= 19 * MS && gap <= 21 * MS, 1);
        bursts(1, base);
        chk(gap >= 74 * MS && gap <= 76 * MS, 1);
        bursts(3, above(base, 5, 8));
        chk(detect, 0);
        bursts(1, above(base, 5, 8));
        chk({detect, out_n_o}, 2'b10);
        repeat (3) @(posedge clk);
        #1;
        chk(s_oe, 1);
        bursts(1, above(base, 5, 3));
        chk(detect, 1);
        bursts(1, above(base, 5, 1));
        chk({detect, out_n_o}, 2'b01);
        chk(ton >= 94 * MS - 8 && ton <= 95 * MS + 9, 1);
        chk(thalf, TH);
        chk(hlen, HB);
        bursts(4, above(base, 5, 8));
        for (int i = 0; i < 210 * MS && detect === 1'b1; i++) @(posedge clk);
        #1;
        chk(cyc - dstamp >= (TO - 1) * MS && cyc - dstamp <= (TO + 1) * MS, 1);
        chk(out_n_o, 1);
        bursts(8, above(base, 5, 8));
        chk(detect, 0);
        // toggle mode: timeout keeps the state, next detection flips it back
        power_up(0, 0, 1, 0);
        bursts(4, above(base, 5, 8));
        chk({detect, out_n_o}, 2'b10);
        for (int i = 0; i < 210 * MS && detect === 1'b1; i++) @(posedge clk);
        #1;
        chk({detect, out_n_o}, 2'b00);
        bursts(4, above(base, 5, 8));
        bursts(4, above(above(base, 5, 8), 5, 8));
        chk({detect, out_n_o}, 2'b11);
        // level mode with the long hold timeout
        power_up(1, 0, 1, 0);
        bursts(4, above(base, 5, 8));
        chk(detect, 1);
        for (int i = 0; i < 410 * MS && detect === 1'b1; i++) @(posedge clk);
        #1;
        chk(cyc - dstamp >= (2 * TO - 1) * MS && cyc - dstamp <= (2 * TO + 1) * MS, 1);
        chk(out_n_o, 1);
        tone_seen = 0;
        power_up(0, 1, 0, 1);
        bursts(4, above(base, 5, 6));
        chk(detect, 0);
        plen = 0;
        bursts(4, above(base, 4, 8));
        chk({detect, out_n_o}, 2'b10);
        for (int i = 0; i < 80 * MS && out_n_o !== 1'b1; i++) @(posedge clk);
        #1;
        chk(plen >= 74 * MS && plen <= 76 * MS, 1);
        chk(tone_seen, 0);
        end_sim;
    end
endmodule
